// File: src/rstc_pkg.sv
// package: constants for the reset controller
package rstc_pkg;
	// ************************************************
	// register map (word offsets, byte addresses)
	// ************************************************
	localparam logic [3:0] ADDR_CAUSE  = 4'h0;   // reset_cause_register
	localparam logic [3:0] ADDR_CTRL   = 4'h4;   // fuses and enables
	localparam logic [3:0] ADDR_STATUS = 4'h8;   // live state, read only
	localparam logic [3:0] ADDR_IRQ    = 4'hC;   // sticky events, read clears
	localparam logic [3:0] ADDR_MASK   = 4'h0;   // mask lives at index 4
	localparam logic [4:0] ADDR_MASK_W = 5'h10;  // mask byte address
	// cause flag positions
	localparam int BIT_PON  = 0;
	localparam int BIT_PIN  = 1;
	localparam int BIT_DRP  = 2;
	localparam int BIT_WDOG = 3;
	localparam int N_SRC    = 4;
	// control field layout
	localparam int CTRL_SUT_LO  = 0;   // startup_time_fuses, 2 bits
	localparam int CTRL_CKS_LO  = 2;   // clock_select_fuses, 4 bits
	localparam int CTRL_DRP_EN  = 6;   // supply_droop_detector enable
	localparam int CTRL_WD_EN   = 7;   // watchdog enable
	localparam int CTRL_WD_IRQ  = 8;   // watchdog interrupt option
	localparam int CTRL_W       = 9;
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h0_03;
	// timing
	localparam real CLK_MHZ     = 125.0;
	localparam real T_PIN_US    = 2.5;  // pin pulse width, longest
	localparam int  PIN_CYC     = int'($floor(T_PIN_US * CLK_MHZ));
	localparam int  DLY_W       = 24;
	localparam logic [DLY_W-1:0] DLY_BASE = 24'h00_0010;
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
	// controller states
	typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} rst_state_t;
endpackage

// File: src/mcu_reset_controller.sv
// reset controller: source merge, stretch counter, cause flags, wishbone
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
// Notes on behaviour
// - internal reset loads registers, fetch restarts
// - any active source forces pins asynchronously
// - stretch reset until delay counter expires
// - fuse settings choose the stretch length
// - internal reset ORs four sources
// - power-on request follows low-supply detector
// - pin low beyond pulse width raises request
// - watchdog request needs expiry, enable, no-irq
// - droop request needs enable and low supply
// - supply rise starts the delay counter
// - supply loss reasserts reset at once
// - watchdog pulse one cycle, count after it
// - four cause flags, zero-write clears, power-on
module mcu_reset_controller
	import rstc_pkg::*;
#(
	parameter int PIN_CYCLES = rstc_pkg::PIN_CYC
)(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	// supply monitors and pins
	input  wire logic        i_supply_low,     // below power_on_threshold
	input  wire logic        i_droop_low,      // below droop_threshold
	input  wire logic        i_pin_resetn,     // external reset pin
	input  wire logic        i_wdog_expired,   // watchdog period elapsed
	// reset outputs
	output logic             o_port_resetn,    // asynchronous port reset
	output logic             o_core_resetn,    // stretched internal reset
	output logic             o_fetch_vector,   // fetch from reset vector
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [4:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	// interrupt
	output logic             o_irq
);
	import rstc_pkg::*;

	// ************************************************
	// state
	// ************************************************
	logic [CTRL_W-1:0] ctrl_r;        // fuses and enables
	logic [N_SRC-1:0]  cause_r;       // reset_cause_register
	logic [N_SRC-1:0]  irq_r;         // sticky events
	logic [N_SRC-1:0]  mask_r;        // interrupt mask
	logic [15:0]       pin_cnt_r;     // pin low filter
	logic              pin_req_r;     // filtered pin request
	logic              wd_exp_r;      // watchdog expiry, delayed
	logic              wd_pulse_r;    // one-cycle watchdog request
	logic [DLY_W-1:0]  dly_cnt_r;     // stretch counter
	rst_state_t        state_r;       // controller state
	logic              ack_r;         // bus answer
	logic [31:0]       rdat_r;        // read data
	logic [N_SRC-1:0]  src_seen_r;    // sources since last release

	// ************************************************
	// source requests
	// ************************************************
	wire por_req   = i_supply_low;
	wire drop_req  = ctrl_r[CTRL_DRP_EN] & i_droop_low;
	wire wd_cond   = i_wdog_expired & ctrl_r[CTRL_WD_EN]
		& ~ctrl_r[CTRL_WD_IRQ];
	wire wd_rise   = wd_cond & ~wd_exp_r;
	wire [N_SRC-1:0] src_vec;
	assign src_vec[BIT_PON]  = por_req;
	assign src_vec[BIT_PIN]  = pin_req_r;
	assign src_vec[BIT_DRP]  = drop_req;
	assign src_vec[BIT_WDOG] = wd_pulse_r;
	wire any_src   = |src_vec;

	// ports forced even without a clock
	assign o_port_resetn = ~(any_src | ~i_pin_resetn | ~i_resetn);

	// ************************************************
	// stretch length from fuses
	// ************************************************
	wire [1:0] sut_f = ctrl_r[CTRL_SUT_LO +: 2];
	wire [3:0] cks_f = ctrl_r[CTRL_CKS_LO +: 4];
	wire [DLY_W-1:0] dly_len = (DLY_BASE << sut_f)
		+ {cks_f, 4'h0};
	wire dly_done = (dly_cnt_r >= dly_len);

	// ************************************************
	// bus decode
	// ************************************************
	wire bus_req   = i_wb_cyc & i_wb_stb & ~ack_r;
	wire bus_wr    = bus_req & i_wb_we & i_wb_sel[0];
	wire hit_cause = (i_wb_adr == {1'b0, ADDR_CAUSE});
	wire hit_ctrl  = (i_wb_adr == {1'b0, ADDR_CTRL});
	wire hit_stat  = (i_wb_adr == {1'b0, ADDR_STATUS});
	wire hit_irq   = (i_wb_adr == {1'b0, ADDR_IRQ});
	wire hit_mask  = (i_wb_adr == ADDR_MASK_W);
	wire rd_irq    = bus_req & ~i_wb_we & hit_irq;
	wire wr_ctrl   = bus_wr & hit_ctrl;
	wire wr_cause  = bus_wr & hit_cause;
	wire wr_mask   = bus_wr & hit_mask;
	wire [N_SRC-1:0] cause_set = src_seen_r & {N_SRC{state_r == ST_HOLD}};
	// a zero written clears a flag, a one leaves it as it is
	wire [N_SRC-1:0] cause_keep = wr_cause ?
		(cause_r & i_wb_dat[N_SRC-1:0]) : cause_r;
	wire [31:0] rd_mux =
		hit_cause ? {28'h000_0000, cause_r} :
		hit_ctrl  ? {23'h00_0000, ctrl_r} :
		hit_stat  ? {26'h000_0000, o_core_resetn, wd_pulse_r,
			pin_req_r, drop_req, por_req, any_src} :
		hit_irq   ? {28'h000_0000, irq_r} :
		hit_mask  ? {28'h000_0000, mask_r} : BUS_ZERO;

	// ************************************************
	// pin filter: low for longer than the pulse width
	// ************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pin_cnt_r <= 16'h0000;
			pin_req_r <= 1'b0;
		end
		else if (i_pin_resetn)
		begin
			pin_cnt_r <= 16'h0000;                          // pin released
			pin_req_r <= 1'b0;
		end
		else if (pin_cnt_r >= 16'(PIN_CYCLES))
			pin_req_r <= 1'b1;
		else
			pin_cnt_r <= pin_cnt_r + 16'h0001;
	end

	// ************************************************
	// watchdog pulse, one clock long
	// ************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			wd_exp_r   <= 1'b0;
			wd_pulse_r <= 1'b0;
		end
		else
		begin
			wd_exp_r   <= wd_cond;
			wd_pulse_r <= wd_rise;
		end
	end

	// ************************************************
	// stretch state machine
	// ************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_r    <= ST_HOLD;
			dly_cnt_r  <= '0;
			src_seen_r <= '0;
		end
		else if (any_src)
		begin
			state_r    <= ST_HOLD;
			dly_cnt_r  <= '0;
			src_seen_r <= src_seen_r | src_vec;
		end
		else
		begin
			case (state_r)
				ST_HOLD:
				begin
					state_r   <= ST_STRETCH;
					dly_cnt_r <= '0;
					src_seen_r <= '0;
				end
				ST_STRETCH:
					if (dly_done)
						state_r <= ST_RUN;
					else
						dly_cnt_r <= dly_cnt_r + 1'b1;
				ST_RUN:
					state_r <= ST_RUN;
				default:
					state_r <= ST_HOLD;
			endcase
		end
	end

	// internal reset held outside run state
	assign o_core_resetn  = (state_r == ST_RUN) & ~any_src;
	assign o_fetch_vector = (state_r == ST_STRETCH) & dly_done;

	// ************************************************
	// cause flags, set wins over software clear
	// ************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			cause_r <= '0;
		else if (cause_set[BIT_PON])
			cause_r <= 4'h1 << BIT_PON;
		else
			cause_r <= cause_keep | cause_set;
	end

	// ************************************************
	// control, mask, sticky interrupt status
	// ************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ctrl_r <= CTRL_RST;
			mask_r <= '0;
			irq_r  <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= i_wb_dat[CTRL_W-1:0];
			if (wr_mask)
				mask_r <= i_wb_dat[N_SRC-1:0];
			irq_r <= (rd_irq ? '0 : irq_r) | cause_set;     // set wins
		end
	end

	assign o_irq = |(irq_r & mask_r);

	// ************************************************
	// bus answer, one cycle after the request
	// ************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ack_r  <= 1'b0;
			rdat_r <= BUS_ZERO;
		end
		else
		begin
			ack_r  <= bus_req;
			rdat_r <= bus_req ? rd_mux : rdat_r;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;
endmodule

// File: testbench/rstc_properties.sv
// checker: port timing relations of the reset controller
`timescale 1ns/1ps
module rstc_properties #(parameter int PIN_CYCLES = 8)(
	input wire logic        i_mclk,
	input wire logic        i_resetn,
	input wire logic        i_supply_low,
	input wire logic        i_droop_low,
	input wire logic        i_pin_resetn,
	input wire logic        i_wdog_expired,
	input wire logic        o_port_resetn,
	input wire logic        o_core_resetn,
	input wire logic        o_fetch_vector,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [4:0]  i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        o_irq
);
	logic [9:0] hi_cnt_r;  // cycles with all sources quiet
	logic [9:0] pin_cnt_r; // cycles with the pin held low
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// saturating counters
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			hi_cnt_r  <= 10'h000;
			pin_cnt_r <= 10'h000;
		end
		else
		begin
			hi_cnt_r  <= o_port_resetn ? hi_cnt_r + 10'(hi_cnt_r != 10'h3ff) : '0;
			pin_cnt_r <= i_pin_resetn ? '0 : pin_cnt_r + 10'(pin_cnt_r != 10'h3ff);
		end
	end
	a_supply_forces_port: assert property (i_supply_low |-> !o_port_resetn)
		else $error("port reset not low with supply low");
	a_core_held_low: assert property (!o_port_resetn && i_pin_resetn
		|-> !o_core_resetn)
		else $error("core reset released with a source active");
	a_supply_loss_now: assert property ($rose(i_supply_low) |-> !o_core_resetn)
		else $error("supply loss did not reassert reset");
	a_stretch_min: assert property ($rose(o_core_resetn) |-> hi_cnt_r >= 10'd15)
		else $error("internal reset released too early");
	a_pin_long_resets: assert property (pin_cnt_r > 10'(PIN_CYCLES + 3)
		|-> !o_core_resetn)
		else $error("long pin pulse gave no reset");
	a_fetch_before_run: assert property (o_fetch_vector |-> !o_core_resetn ##1 o_core_resetn)
		else $error("fetch pulse not in last stretch cycle");
	a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_next_edge: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack not one cycle after request");
	c_run: cover property ($rose(o_core_resetn));
	c_fetch: cover property (o_fetch_vector);
	c_irq: cover property ($rose(o_irq));
endmodule
bind mcu_reset_controller rstc_properties #(.PIN_CYCLES(PIN_CYCLES)) u_props (.*);

// File: testbench/rstc_partner.sv
// partner: supply monitors, reset pin and watchdog on command
`timescale 1ns/1ps
module rstc_partner (
	input  wire logic       i_mclk,
	input  wire logic [3:0] i_cmd,  // [0]supply [1]pin [2]droop [3]wdog
	output logic            o_supply_low,
	output logic            o_droop_low,
	output logic            o_pin_resetn,  // pulled up when not driven
	output logic            o_wdog_expired
);
	// levels follow the command one edge later
	always_ff @(posedge i_mclk)
	begin
		o_supply_low   <= i_cmd[0];
		o_pin_resetn   <= !i_cmd[1];
		o_droop_low    <= i_cmd[2];
		o_wdog_expired <= i_cmd[3];
	end
endmodule

// File: testbench/testbench.sv
// testbench: reset sequences, cause flags and register bus
`timescale 1ns/1ps
`define CHK(g,e) begin compares++; if ((g) !== (e)) begin miscompares++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import rstc_pkg::*;
	localparam int PC = 8;
	logic i_mclk = 0, i_resetn = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
	logic [4:0] i_wb_adr = 5'h00;
	logic [31:0] i_wb_dat = 32'h0000_0000, seed = 32'hcee9_819b;
	logic [3:0] cmd = 4'h1;
	logic sup, drp, pin, wd, prt, core, fv, ack, irq, pcore = 0;
	logic [31:0] rd, exp_q[$];
	int miscompares = 0, compares = 0, cnt = 0, bm = -1, be = 0, len_q[$];
	always #4 i_mclk = ~i_mclk;
	rstc_partner far (.i_mclk, .i_cmd(cmd), .o_supply_low(sup), .o_droop_low(drp),
		.o_pin_resetn(pin), .o_wdog_expired(wd));
	mcu_reset_controller #(.PIN_CYCLES(PC)) dut (.i_mclk, .i_resetn,
		.i_supply_low(sup), .i_droop_low(drp), .i_pin_resetn(pin),
		.i_wdog_expired(wd), .o_port_resetn(prt), .o_core_resetn(core),
		.o_fetch_vector(fv), .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
		.i_wb_sel(4'hf), .i_wb_dat, .o_wb_dat(rd), .o_wb_ack(ack), .o_irq(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task wrap_up;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one classic cycle; a read notes its expected word
	task bus(input logic we, input logic [4:0] a, input logic [31:0] d, e);
		int n;
		if (!we) exp_q.push_back(e);
		@(posedge i_mclk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, a, d};
		n = 0;
		do begin @(posedge i_mclk); n++; end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin miscompares++; wrap_up; end
		{i_wb_cyc, i_wb_stb} <= 2'b00;
	endtask
	task src(input logic [3:0] c, input int n);
		@(posedge i_mclk);
		cmd <= c;
		repeat (n) @(posedge i_mclk);
		cmd <= 4'h0;
	endtask
	task wait_run(input int e);
		int n;
		len_q.push_back(e);
		n = 0;
		do begin @(posedge i_mclk); n++; end while (core !== 1'b1 && n < 2000);
		if (n >= 2000) begin miscompares++; wrap_up; end
	endtask
	// watcher: read data on ack, stretch length on each release
	always @(posedge i_mclk)
	begin
		if (ack === 1'b1 && !i_wb_we && exp_q[0] !== 'x) `CHK(rd, exp_q[0])
		if (ack === 1'b1 && !i_wb_we) void'(exp_q.pop_front());
		cnt <= (prt !== 1'b1) ? 0 : cnt + 1;
		pcore <= core;
		if (core === 1'b1 && pcore !== 1'b1 && len_q.size() > 0)
		begin
			if (bm < 0) begin bm = cnt; be = len_q.pop_front(); end
			else `CHK(cnt - bm, len_q.pop_front() - be)
		end
	end
	initial
	begin
		repeat (6) @(posedge i_mclk);
		i_resetn <= 1'b1;
		repeat (20) @(posedge i_mclk);
		cmd <= 4'h0;
		wait_run(128);
		bus(0, 5'h00, 0, 32'h0000_0001);
		bus(0, 5'h04, 0, 32'h0000_0003);
		bus(1, 5'h14, seed, 0);
		bus(0, 5'h14, 0, 32'h0000_0000);
		bus(1, 5'h04, 32'h0000_0004, 0);
		seed = lfsr(seed);
		src(4'h2, seed % 5 + 1);
		bus(0, 5'h08, 0, 32'h0000_0020);
		bus(1, 5'h00, 0, 0);
		src(4'h2, PC + 4);
		wait_run(32);
		bus(0, 5'h00, 0, 32'h0000_0002);
		bus(1, 5'h04, 32'h0000_0184, 0);
		src(4'h8, 3);
		src(4'h4, 3);
		bus(0, 5'h08, 0, 32'h0000_0020);
		bus(1, 5'h04, 32'h0000_0084, 0);
		src(4'h8, 3);
		wait_run(32);
		bus(0, 5'h00, 0, 32'h0000_000a);
		bus(0, 5'h0c, 0, 32'h0000_000b);
		bus(1, 5'h10, 32'h0000_0004, 0);
		bus(1, 5'h04, 32'h0000_0044, 0);
		src(4'h4, 4);
		repeat (10) @(posedge i_mclk);
		src(4'h4, 2);
		wait_run(32);
		`CHK(irq, 1'b1)
		bus(0, 5'h0c, 0, 32'h0000_0004);
		@(posedge i_mclk);
		`CHK(irq, 1'b0)
		wrap_up;
	end
endmodule
